// File: nor_front_cfg.svh
/*
 constants for the flash bus front end: command codes, config bit
 positions, reset values and timing counts. assumes a 250 MHz clock.
*/
`ifndef NOR_FRONT_CFG_SVH
`define NOR_FRONT_CFG_SVH
`define CMD_READ_ARRAY   8'hff
`define CMD_READ_STATUS  8'h70
`define CMD_READ_IDENT   8'h90
`define CMD_READ_QUERY   8'h98
`define CMD_CLEAR_STATUS 8'h50
`define CMD_ERASE_SETUP  8'h20
`define CMD_PROG_SETUP   8'h40
`define CMD_PROG_ALT     8'h10
`define CMD_BUF_PROG     8'he8
`define CMD_EFP_SETUP    8'h80
`define CMD_BLANK_SETUP  8'hbc
`define CMD_BLANK_CONF   8'hcb
`define CMD_PROT_PROG    8'hc0
`define CMD_SUSPEND      8'hb0
`define CMD_CONFIRM      8'hd0
`define CMD_LOCK_SETUP   8'h60
`define CMD_LOCK         8'h01
`define CMD_LOCKDOWN     8'h2f
`define CMD_SET_CFG      8'h03
`define CFG_RESET        16'h0000
`define CFG_ROLE_POS     4
`define CFG_POL_POS      10
`define SR_READY_POS     7
`define SR_ERASE_FAIL    5
`define SR_PROG_FAIL     4
`define SR_ERR_MASK      8'h3a
`define RW_LOW_DELAY_NS  40
`define RW_LOW_DELAY_CYC ((`RW_LOW_DELAY_NS + 3) / 4)
`define PE_BUSY_CYC      64
`endif

// File: nor_front_pkg.sv
/*
 types for the two ends of the flash bus: read modes for the device, host states for the host.
 assumes nor_front_cfg.svh for the constants.
*/
package nor_front_pkg;
    typedef enum logic [3:0] {
        RD_ARRAY  = 4'h1,
        RD_STATUS = 4'h2,
        RD_IDENT  = 4'h4,
        RD_QUERY  = 4'h8
    } read_mode_t;
    typedef enum logic [4:0] {
        H_IDLE  = 5'h01,
        H_SETUP = 5'h02,
        H_PULSE = 5'h04,
        H_HOLD  = 5'h08,
        H_DONE  = 5'h10
    } host_state_t;
endpackage : nor_front_pkg

// File: nor_bus_if.sv
/*
 parallel flash bus between host and device. resolves the data lines
 and ready/wait pin from active-low output enables.
*/
`timescale 1ns/10ps
interface nor_bus_if;
    logic        chip_sel_n;
    logic        out_gate_n;
    logic        wr_strobe_n;
    logic        addr_latch_n;
    logic        hard_reset_n;
    logic [22:0] addr;
    logic [15:0] host_dq_out;
    logic        host_dq_oe_n;
    logic [15:0] dev_dq_out;
    logic        dev_dq_oe_n;
    logic        rw_out;
    logic        rw_oe_n;
    wire  [15:0] data_lines = !dev_dq_oe_n ? dev_dq_out :
                              !host_dq_oe_n ? host_dq_out : 16'hffff;
    wire         ready_wait = !rw_oe_n ? rw_out : 1'b1;
    modport device (input chip_sel_n, out_gate_n, wr_strobe_n,
                    addr_latch_n, hard_reset_n, addr, data_lines,
                    output dev_dq_out, dev_dq_oe_n, rw_out, rw_oe_n);
    modport host (output chip_sel_n, out_gate_n, wr_strobe_n,
                  addr_latch_n, hard_reset_n, addr, host_dq_out,
                  host_dq_oe_n, input data_lines, ready_wait);
endinterface : nor_bus_if

// File: nor_flash_front.sv
/*
 device end: bus operation decoder, command interpreter, program/erase
 sequencer and status. control pins arrive asynchronously and are synchronised; address and data are registered once.
 the array content comes from user logic through array_rdata_i.
*/
`timescale 1ns/10ps
`include "nor_front_cfg.svh"
module nor_flash_front
    import nor_front_pkg::*;
#(
    parameter int ADDR_W   = 23,
    parameter int BUSY_CYC = `PE_BUSY_CYC
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    nor_bus_if.device              bus,
    input  wire logic [15:0]       array_rdata_i,
    input  wire logic [15:0]       ident_rdata_i,
    input  wire logic [15:0]       query_rdata_i,
    output logic [ADDR_W-1:0]      op_addr_o,
    output logic [15:0]            op_data_o,
    output logic [7:0]             op_code_o,
    output logic                   op_start_o,
    output logic                   op_abort_o,
    output logic                   busy_o,
    output logic                   standby_o
);
    logic [2:0]        s_ce, s_oe, s_we, s_le, s_rp;
    logic [2:0]        next_s_ce, next_s_oe, next_s_we, next_s_le, next_s_rp;
    logic              ce_n, oe_n, we_n, le_n, rp_n;
    logic              next_ce_n, next_oe_n, next_we_n, next_le_n, next_rp_n;
    logic [ADDR_W-1:0] addr_q, next_addr_q, held_addr, next_held_addr;
    logic [15:0]       din_q, next_din_q;
    read_mode_t        mode, next_mode;
    logic [7:0]        pend, next_pend;
    logic [7:0]        status, next_status;
    logic [15:0]       cfg, next_cfg;
    logic [15:0]       busy_cnt, next_busy_cnt;
    logic [7:0]        rw_cnt, next_rw_cnt;
    logic [15:0]       dq, next_dq;
    logic [ADDR_W-1:0] next_op_addr;
    logic [15:0]       next_op_data;
    logic [7:0]        next_op_code;
    logic              next_op_start, next_op_abort;
    logic              wr_end, busy;
    logic [7:0]        code;
    logic              role_q, next_role_q, role;

    assign busy = busy_cnt != 16'h0000;
    assign wr_end = !rp_n ? 1'b0 :
                    (!ce_n && !we_n && oe_n) &&
                    (next_ce_n || next_we_n);
    assign code = din_q[7:0];

    always_comb begin
        // three-stage pin synchronisers; stages 2 and 3 must agree
        next_s_ce = {s_ce[1:0], bus.chip_sel_n};
        next_s_oe = {s_oe[1:0], bus.out_gate_n};
        next_s_we = {s_we[1:0], bus.wr_strobe_n};
        next_s_le = {s_le[1:0], bus.addr_latch_n};
        next_s_rp = {s_rp[1:0], bus.hard_reset_n};
        next_ce_n = (s_ce[2] == s_ce[1]) ? s_ce[2] : ce_n;
        next_oe_n = (s_oe[2] == s_oe[1]) ? s_oe[2] : oe_n;
        next_we_n = (s_we[2] == s_we[1]) ? s_we[2] : we_n;
        next_le_n = (s_le[2] == s_le[1]) ? s_le[2] : le_n;
        next_rp_n = (s_rp[2] == s_rp[1]) ? s_rp[2] : rp_n;
        next_addr_q = bus.addr[ADDR_W-1:0];
        next_din_q = bus.data_lines;
        next_held_addr = held_addr;
        if (!ce_n && !le_n && next_le_n) begin
            next_held_addr = addr_q;
        end else if (!ce_n && le_n) begin
            next_held_addr = held_addr;
        end else if (!le_n) begin
            next_held_addr = addr_q;
        end
        next_mode = mode;
        next_pend = pend;
        next_status = status;
        next_cfg = cfg;
        next_busy_cnt = busy ? busy_cnt - 16'h0001 : busy_cnt;
        next_op_addr = op_addr_o;
        next_op_data = op_data_o;
        next_op_code = op_code_o;
        next_op_start = 1'b0;
        next_op_abort = 1'b0;
        if (wr_end) begin
            if (pend == 8'h00) begin
                case (code)
                `CMD_READ_ARRAY:   next_mode = RD_ARRAY;
                `CMD_READ_STATUS:  next_mode = RD_STATUS;
                `CMD_READ_IDENT:   next_mode = RD_IDENT;
                `CMD_READ_QUERY:   next_mode = RD_QUERY;
                `CMD_CLEAR_STATUS: next_status = status & ~`SR_ERR_MASK;
                `CMD_ERASE_SETUP, `CMD_PROG_SETUP, `CMD_PROG_ALT,
                `CMD_BUF_PROG, `CMD_EFP_SETUP, `CMD_BLANK_SETUP,
                `CMD_PROT_PROG, `CMD_LOCK_SETUP: begin
                    if (!busy) next_pend = code;
                end
                `CMD_SUSPEND, `CMD_CONFIRM: next_mode = mode;
                default: next_mode = mode;
                endcase
            end else begin
                next_pend = 8'h00;
                next_op_addr = held_addr;
                next_op_data = din_q;
                next_op_code = pend;
                case (pend)
                `CMD_PROG_SETUP, `CMD_PROG_ALT, `CMD_PROT_PROG: begin
                    next_op_start = 1'b1;
                    next_mode = RD_STATUS;
                end
                `CMD_ERASE_SETUP, `CMD_BUF_PROG, `CMD_EFP_SETUP,
                `CMD_BLANK_SETUP: begin
                    if (code == ((pend == `CMD_BLANK_SETUP) ?
                                 `CMD_BLANK_CONF : `CMD_CONFIRM)) begin
                        next_op_start = 1'b1;
                    end else begin
                        next_status[`SR_ERASE_FAIL] = 1'b1;
                        next_status[`SR_PROG_FAIL] = 1'b1;
                    end
                    next_mode = RD_STATUS;
                end
                `CMD_LOCK_SETUP: begin
                    case (code)
                    `CMD_SET_CFG: next_cfg = held_addr[15:0];
                    `CMD_LOCK, `CMD_CONFIRM, `CMD_LOCKDOWN:
                        next_op_start = 1'b1;
                    default: next_op_start = 1'b0;
                    endcase
                end
                default: next_pend = 8'h00;
                endcase
            end
        end
        next_status[`SR_READY_POS] = !busy;
        if (next_op_start) begin
            next_busy_cnt = 16'(BUSY_CYC);
        end
        next_rw_cnt = rw_cnt;
        next_role_q = rp_n ? cfg[`CFG_ROLE_POS] : role_q;
        if (!rp_n) begin
            next_mode = RD_ARRAY;
            next_pend = 8'h00;
            next_cfg = `CFG_RESET;
            next_op_abort = busy;
            next_busy_cnt = 16'h0000;
            if (rw_cnt != 8'(`RW_LOW_DELAY_CYC)) next_rw_cnt = rw_cnt + 8'h01;
        end else begin
            next_rw_cnt = 8'h00;
        end
        case (mode)
        RD_STATUS: next_dq = {8'h00, status};
        RD_IDENT:  next_dq = ident_rdata_i;
        RD_QUERY:  next_dq = query_rdata_i;
        default:   next_dq = array_rdata_i;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_ce <= 3'h7; s_oe <= 3'h7; s_we <= 3'h7;
            s_le <= 3'h7; s_rp <= 3'h0;
            ce_n <= 1'b1; oe_n <= 1'b1; we_n <= 1'b1;
            le_n <= 1'b1; rp_n <= 1'b0;
            addr_q <= '0; held_addr <= '0; din_q <= 16'h0000;
            mode <= RD_ARRAY; pend <= 8'h00; status <= 8'h80;
            cfg <= `CFG_RESET; busy_cnt <= 16'h0000; rw_cnt <= 8'h00;
            role_q <= 1'b0;
            dq <= 16'h0000; op_addr_o <= '0; op_data_o <= 16'h0000;
            op_code_o <= 8'h00; op_start_o <= 1'b0; op_abort_o <= 1'b0;
        end else begin
            s_ce <= next_s_ce; s_oe <= next_s_oe; s_we <= next_s_we;
            s_le <= next_s_le; s_rp <= next_s_rp;
            ce_n <= next_ce_n; oe_n <= next_oe_n; we_n <= next_we_n;
            le_n <= next_le_n; rp_n <= next_rp_n;
            addr_q <= next_addr_q; held_addr <= next_held_addr;
            din_q <= next_din_q; mode <= next_mode; pend <= next_pend;
            status <= next_status; cfg <= next_cfg;
            busy_cnt <= next_busy_cnt; rw_cnt <= next_rw_cnt; dq <= next_dq;
            role_q <= next_role_q;
            op_addr_o <= next_op_addr; op_data_o <= next_op_data;
            op_code_o <= next_op_code; op_start_o <= next_op_start;
            op_abort_o <= next_op_abort;
        end
    end

    // output drivers
    assign busy_o = busy;
    assign standby_o = rp_n && ce_n && !busy;
    assign bus.dev_dq_out = dq;
    assign bus.dev_dq_oe_n = !(rp_n && !ce_n && !oe_n && we_n);
    // pin role frozen at reset entry, so the restored default
    // does not cancel the ready low during reset
    assign role = rp_n ? cfg[`CFG_ROLE_POS] : role_q;
    assign bus.rw_out = role ? 1'b0 :
                        (busy ^ !cfg[`CFG_POL_POS]);
    assign bus.rw_oe_n = role ?
        !(!rp_n && rw_cnt == 8'(`RW_LOW_DELAY_CYC)) :
        !(rp_n && !ce_n && !oe_n);
endmodule : nor_flash_front

// File: nor_flash_host.sv
/*
 host end: runs one bus read or write per request on the flash bus,
 with address latch pulse before each. pins are decoded from flops, but hard_reset_n follows flash_reset_i directly.
 the device data lines are sampled through three flops.
*/
`timescale 1ns/10ps
`include "nor_front_cfg.svh"
module nor_flash_host
    import nor_front_pkg::*;
#(
    parameter int PHASE_CYC = 8
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    nor_bus_if.host          bus,
    input  wire logic        req_i,
    input  wire logic        req_write_i,
    input  wire logic [22:0] req_addr_i,
    input  wire logic [15:0] req_wdata_i,
    input  wire logic        flash_reset_i,
    output logic             req_ready_o,
    output logic [15:0]      rdata_o,
    output logic             rdata_valid_o
);
    host_state_t state, next_state;
    logic [7:0]  cnt, next_cnt;
    logic        wr, next_wr;
    logic [22:0] addr, next_addr;
    logic [15:0] wdata, next_wdata;
    logic [15:0] s1, s2, s3, next_rdata;
    logic        next_valid;

    always_comb begin
        next_state = state;
        next_cnt = (cnt != 8'h00) ? cnt - 8'h01 : cnt;
        next_wr = wr;
        next_addr = addr;
        next_wdata = wdata;
        next_rdata = rdata_o;
        next_valid = 1'b0;
        case (state)
        H_IDLE: if (req_i && !flash_reset_i) begin
            next_state = H_SETUP;
            next_wr = req_write_i;
            next_addr = req_addr_i;
            next_wdata = req_wdata_i;
            next_cnt = 8'(PHASE_CYC);
        end
        H_SETUP: if (cnt == 8'h00) begin
            next_state = H_PULSE;
            next_cnt = 8'(PHASE_CYC);
        end
        H_PULSE: if (cnt == 8'h00) begin
            next_state = H_HOLD;
            next_cnt = 8'(PHASE_CYC);
            if (!wr) begin
                next_rdata = s3;
                next_valid = 1'b1;
            end
        end
        H_HOLD: if (cnt == 8'h00) next_state = H_DONE;
        H_DONE: next_state = H_IDLE;
        default: next_state = H_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= H_IDLE; cnt <= 8'h00; wr <= 1'b0;
            addr <= 23'h000000; wdata <= 16'h0000;
            s1 <= 16'h0000; s2 <= 16'h0000; s3 <= 16'h0000;
            rdata_o <= 16'h0000; rdata_valid_o <= 1'b0;
        end else begin
            state <= next_state; cnt <= next_cnt; wr <= next_wr;
            addr <= next_addr; wdata <= next_wdata;
            s1 <= bus.data_lines; s2 <= s1; s3 <= s2;
            rdata_o <= next_rdata; rdata_valid_o <= next_valid;
        end
    end

    // pins: latch low in setup, select held through pulse
    assign req_ready_o = state == H_IDLE && !flash_reset_i;
    assign bus.hard_reset_n = !flash_reset_i;
    assign bus.chip_sel_n = !(state == H_SETUP || state == H_PULSE);
    assign bus.addr_latch_n = state != H_SETUP;
    assign bus.addr = addr;
    assign bus.wr_strobe_n = !(state == H_PULSE && wr);
    assign bus.out_gate_n = !(state == H_PULSE && !wr);
    assign bus.host_dq_out = wdata;
    assign bus.host_dq_oe_n = !(state != H_IDLE && wr);
endmodule : nor_flash_host

// File: nor_bus_asserts.sv
/*
 checker for the flash bus wire between host end and device end.
 assumes it is instantiated beside nor_bus_if with its signals by name.
*/
`timescale 1ns/10ps
module nor_bus_asserts (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic chip_sel_n,
    input  wire logic out_gate_n,
    input  wire logic wr_strobe_n,
    input  wire logic addr_latch_n,
    input  wire logic hard_reset_n,
    input  wire logic host_dq_oe_n,
    input  wire logic dev_dq_oe_n
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_read_drives;
        (!chip_sel_n && !out_gate_n && wr_strobe_n && hard_reset_n)[*6]
            |-> !dev_dq_oe_n;
    endproperty
    a_read_drives: assert property (p_read_drives)
        else $error("device not driving during bus read");

    property p_gate_floats;
        out_gate_n[*6] |-> dev_dq_oe_n;
    endproperty
    a_gate_floats: assert property (p_gate_floats)
        else $error("device drives data with gate high");

    property p_standby_floats;
        (chip_sel_n && hard_reset_n)[*6] |-> dev_dq_oe_n;
    endproperty
    a_standby_floats: assert property (p_standby_floats)
        else $error("device drives data in standby");

    property p_reset_floats;
        (!hard_reset_n)[*6] |-> dev_dq_oe_n;
    endproperty
    a_reset_floats: assert property (p_reset_floats)
        else $error("device drives data in reset");

    property p_no_clash;
        !dev_dq_oe_n |-> host_dq_oe_n;
    endproperty
    a_no_clash: assert property (p_no_clash)
        else $error("both ends drive the data lines");

    property p_host_write_gate;
        !wr_strobe_n |-> out_gate_n && !chip_sel_n;
    endproperty
    a_host_write_gate: assert property (p_host_write_gate)
        else $error("write strobe low without select or with gate low");

    property p_latch_sel;
        !addr_latch_n |-> !chip_sel_n;
    endproperty
    a_latch_sel: assert property (p_latch_sel)
        else $error("address latch strobe low while deselected");

    property p_strobe_width;
        $fell(wr_strobe_n) |-> (!wr_strobe_n)[*8];
    endproperty
    a_strobe_width: assert property (p_strobe_width)
        else $error("write strobe pulse too short to be captured");
endmodule : nor_bus_asserts

// File: tb_top.sv
/*
 testbench joining host end and device end over the flash bus.
 assumes the interface, package and both design modules are compiled.
*/
`timescale 1ns/10ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
    failures++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top;
    typedef struct packed {logic [15:0] cmd; logic [15:0] exp;} row_t;
    localparam logic [15:0] ARR = 16'ha5c3;
    localparam logic [15:0] IDN = 16'h1d2e;
    localparam logic [15:0] QRY = 16'h0051;
    localparam logic [22:0] EA  = 23'h123456;
    localparam logic [22:0] PA  = 23'h000a5a;
    logic        clk_i, rst_i, req_i, req_write_i, flash_reset_i;
    logic [22:0] req_addr_i, op_addr_o;
    logic [15:0] req_wdata_i, rdata_o, op_data_o, rdata;
    logic        req_ready_o, rdata_valid_o, op_start_o, op_abort_o;
    logic        busy_o, standby_o;
    logic [7:0]  op_code_o;
    int          failures, checked, starts, aborts, s0;
    row_t        rows [4] = '{'{16'hab90, IDN}, '{16'h0098, QRY},
                              '{16'h5570, 16'h0080}, '{16'hc3ff, ARR}};
    nor_bus_if bus();
    nor_flash_front #(.BUSY_CYC(200)) u_nor_flash_front (
        .clk_i(clk_i), .rst_i(rst_i), .bus(bus),
        .array_rdata_i(ARR), .ident_rdata_i(IDN), .query_rdata_i(QRY),
        .op_addr_o(op_addr_o), .op_data_o(op_data_o),
        .op_code_o(op_code_o),
        .op_start_o(op_start_o), .op_abort_o(op_abort_o),
        .busy_o(busy_o), .standby_o(standby_o));
    nor_flash_host u_nor_flash_host (
        .clk_i(clk_i), .rst_i(rst_i), .bus(bus), .req_i(req_i),
        .req_write_i(req_write_i), .req_addr_i(req_addr_i),
        .req_wdata_i(req_wdata_i), .flash_reset_i(flash_reset_i),
        .req_ready_o(req_ready_o), .rdata_o(rdata_o),
        .rdata_valid_o(rdata_valid_o));
    nor_bus_asserts u_chk (
        .clk_i(clk_i), .rst_i(rst_i), .chip_sel_n(bus.chip_sel_n),
        .out_gate_n(bus.out_gate_n), .wr_strobe_n(bus.wr_strobe_n),
        .addr_latch_n(bus.addr_latch_n), .hard_reset_n(bus.hard_reset_n),
        .host_dq_oe_n(bus.host_dq_oe_n), .dev_dq_oe_n(bus.dev_dq_oe_n));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (op_start_o === 1'b1) starts <= starts + 1;
        if (op_abort_o === 1'b1) aborts <= aborts + 1;
    end

    task automatic report_and_stop();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    task automatic wait_on(input int which);
        int n;
        n = 0;
        while ((which == 0 && req_ready_o !== 1'b1) ||
               (which == 1 && rdata_valid_o !== 1'b1) ||
               (which == 2 && busy_o !== 1'b0)) begin
            @(negedge clk_i);
            n++;
            if (n > 1000) begin
                failures++;
                report_and_stop();
            end
        end
    endtask : wait_on

    task automatic xfer(input logic wr, input logic [22:0] a,
                        input logic [15:0] d);
        wait_on(0);
        req_i = 1'b1;
        req_write_i = wr;
        req_addr_i = a;
        req_wdata_i = d;
        @(negedge clk_i);
        req_i = 1'b0;
        if (!wr) begin
            wait_on(1);
            rdata = rdata_o;
        end
        @(negedge clk_i);
        wait_on(0);
    endtask : xfer

    initial begin
        {req_i, req_write_i, flash_reset_i} = 3'h0;
        req_addr_i = 23'h000000;
        req_wdata_i = 16'h0000;
        failures = 0;
        checked = 0;
        starts = 0;
        aborts = 0;
        rst_i = 1'b1;
        repeat (8) @(negedge clk_i);
        rst_i = 1'b0;
        foreach (rows[i]) begin
            xfer(1'b1, 23'h000100, rows[i].cmd);
            xfer(1'b0, 23'h000100, 16'h0000);
            `CHK(rdata, rows[i].exp)
        end
        xfer(1'b1, 23'h000000, 16'h0070);
        xfer(1'b1, 23'h000000, 16'h0060);
        xfer(1'b1, 23'h000010, 16'h0003);
        `CHK(bus.rw_oe_n, 1'b1)
        flash_reset_i = 1'b1;
        repeat (20) @(negedge clk_i);
        `CHK(bus.ready_wait, 1'b0)
        `CHK(bus.dev_dq_oe_n, 1'b1)
        flash_reset_i = 1'b0;
        xfer(1'b0, 23'h000100, 16'h0000);
        `CHK(rdata, ARR)
        s0 = starts;
        xfer(1'b1, EA, 16'h0020);
        xfer(1'b1, EA, 16'h00d0);
        `CHK(starts, s0 + 1)
        `CHK(op_addr_o, EA)
        `CHK(busy_o, 1'b1)
        `CHK(standby_o, 1'b0)
        `CHK(bus.rw_oe_n, 1'b1)
        `CHK(op_code_o, 8'h20)
        xfer(1'b1, EA, 16'h0070);
        xfer(1'b0, EA, 16'h0000);
        `CHK(rdata[7], 1'b0)
        wait_on(2);
        `CHK(standby_o, 1'b1)
        xfer(1'b0, EA, 16'h0000);
        `CHK(rdata, 16'h0080)
        xfer(1'b1, PA, 16'h0040);
        xfer(1'b1, PA, 16'hbeef);
        `CHK(op_data_o, 16'hbeef)
        `CHK(op_addr_o, PA)
        wait_on(2);
        s0 = starts;
        xfer(1'b1, EA, 16'h0020);
        xfer(1'b1, EA, 16'h0010);
        xfer(1'b1, EA, 16'h0070);
        xfer(1'b0, EA, 16'h0000);
        `CHK(rdata, 16'h00b0)
        `CHK(starts, s0)
        xfer(1'b1, EA, 16'h0050);
        xfer(1'b0, EA, 16'h0000);
        `CHK(rdata, 16'h0080)
        s0 = aborts;
        xfer(1'b1, EA, 16'h0020);
        xfer(1'b1, EA, 16'h00d0);
        flash_reset_i = 1'b1;
        repeat (20) @(negedge clk_i);
        `CHK(aborts, s0 + 1)
        `CHK(busy_o, 1'b0)
        `CHK(bus.ready_wait, 1'b1)
        flash_reset_i = 1'b0;
        repeat (10) @(negedge clk_i);
        report_and_stop();
    end
endmodule : tb_top
